// >>> hdl/inverse_time_relay.sv
// inverse-time relay for phase overcurrent, voltage-restrained overcurrent, imbalance
// assumes inputs are synchronous to CLK and ratings are nonzero in normal use
`include "relay_params.svh"

// Overview of operation
// - overcurrent uses largest phase, never sum
// - one multiplier shifts pre-alarm and alarm curves
// - act after continuous excess for live delay
// - alarms latch until reset; always evaluated
// - restrained levels scale with average voltage ratio
// - restrained function otherwise behaves like overcurrent
// - imbalance monitors largest pairwise phase difference
// - imbalance adds rated current before normalising
// - curve input is quantity over its rating
// - delay is D times (A over x^2-1 plus B)
// - multiplier 0.01 to 10.0, default 1.0
// - high type: pre-alarm and alarm above levels
// - low type: mirrored, acting below levels
// - at or below rated: fixed 10 s times D
// - each function owns its multiplier
module inverse_time_relay
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
)
(
  input  wire logic                        CLK,
  input  wire logic                        NRST,
  input  wire relay_pkg::phase_t           I_PHASE,
  input  wire relay_pkg::phase_t           V_PHASE,
  input  wire logic [15:0]                 RATED_I,
  input  wire logic [15:0]                 RATED_V,
  input  wire relay_pkg::relay_cfg_t [2:0] CFG,
  output logic [2:0]                       PRE_ALARM,
  output logic [2:0]                       ALARM
);
  import relay_pkg::*;

  relay_state_t     st;
  relay_state_t     next_st;
  logic [2:0][17:0] mon;
  logic [2:0][17:0] lvl_pre;
  logic [2:0][17:0] lvl_alm;
  logic [2:0][17:0] rated;
  logic [2:0][9:0]  mult_eff;
  logic [5:0]       cond;
  logic [5:0]       fixed;
  logic [5:0][31:0] delay;
  logic             tick_hit;
  logic [17:0]      vavg;
  logic [17:0]      lvl;
  logic [15:0]      x_ratio;
  logic [15:0]      l_ratio;
  logic [1:0]       k;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic [17:0] max3(input logic [17:0] a, input logic [17:0] b,
                                       input logic [17:0] c);
    logic [17:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  function automatic logic [17:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? {2'h0, a - b} : {2'h0, b - a};
  endfunction

  // Q8 ratio, clipped so the power stage cannot overflow its 48 bits
  function automatic logic [15:0] ratio(input logic [17:0] num, input logic [17:0] den);
    logic [31:0] q;
    q = {6'h00, num, 8'h00} / ((den == 18'h00000) ? 32'h0000_0001 : {14'h0000, den});
    return (q > {16'h0000, `RATIO_MAX}) ? `RATIO_MAX : q[15:0];
  endfunction

  // delay in ms; fixed branch swaps the curve constants at the discontinuity
  function automatic logic [31:0] curve_ms(input logic [15:0] x, input logic [9:0] m,
                                           input logic fix);
    logic [47:0] pw;
    logic [47:0] base;
    pw   = `POW_ONE;
    base = 48'h0;
    for (int e = 0; e < `CURVE_EXP; e++)
      pw = 48'((pw * {32'h0, x}) >> `RATIO_FRAC);
    if (fix)
      base = 48'(`FIXED_A_MS) + 48'(`FIXED_B_MS);
    else
      base = (48'(`CURVE_A_MS) << 16) / (pw - `POW_ONE) + 48'(`CURVE_B_MS);
    return 32'((base * {38'h0, m}) / `MULT_SCALE);
  endfunction

  // ----------------------------------------------------------------------------
  // monitored quantities and trigger levels
  // ----------------------------------------------------------------------------
  always_comb
  begin
    vavg = 18'(({2'h0, V_PHASE.a} + {2'h0, V_PHASE.b} + {2'h0, V_PHASE.c}) / 18'h3);
    for (int f = 0; f < `NUM_FN; f++)
    begin
      rated[f]    = {2'h0, RATED_I};
      lvl_pre[f]  = {2'h0, CFG[f].pre_level};
      lvl_alm[f]  = {2'h0, CFG[f].alm_level};
      // zero means unset; each function clamps its own multiplier
      mult_eff[f] = (CFG[f].mult == 10'h000) ? `MULT_DEFAULT :
                    (CFG[f].mult > `MULT_MAX) ? `MULT_MAX : CFG[f].mult;
    end
    mon[`FN_OVC] = max3({2'h0, I_PHASE.a}, {2'h0, I_PHASE.b}, {2'h0, I_PHASE.c});
    mon[`FN_VRO] = mon[`FN_OVC];
    // restraint: both levels follow the voltage 1:1, guarded against zero rating
    lvl_pre[`FN_VRO] = 18'(({16'h0, CFG[`FN_VRO].pre_level} * {14'h0, vavg})
                       / ((RATED_V == 16'h0) ? 32'h1 : {16'h0, RATED_V}));
    lvl_alm[`FN_VRO] = 18'(({16'h0, CFG[`FN_VRO].alm_level} * {14'h0, vavg})
                       / ((RATED_V == 16'h0) ? 32'h1 : {16'h0, RATED_V}));
    // imbalance works in offset units so the curve sees ratios above one
    mon[`FN_IMB] = max3(absdiff(I_PHASE.a, I_PHASE.b), absdiff(I_PHASE.b, I_PHASE.c),
                        absdiff(I_PHASE.c, I_PHASE.a)) + {2'h0, RATED_I};
    lvl_pre[`FN_IMB] = {2'h0, CFG[`FN_IMB].pre_level} + {2'h0, RATED_I};
    lvl_alm[`FN_IMB] = {2'h0, CFG[`FN_IMB].alm_level} + {2'h0, RATED_I};
  end

  // ----------------------------------------------------------------------------
  // per-stage condition and live delay (stage 0 pre-alarm, stage 1 alarm)
  // ----------------------------------------------------------------------------
  always_comb
  begin
    cond    = 6'h00;
    fixed   = 6'h00;
    delay   = '0;
    lvl     = 18'h0;
    x_ratio = 16'h0;
    l_ratio = 16'h0;
    k       = 2'h0;
    for (int t = 0; t < `NUM_TMR; t++)
    begin
      k   = 2'(t / 2);
      lvl = (t % 2 == 0) ? lvl_pre[k] : lvl_alm[k];
      if (CFG[k].low_type)
      begin
        cond[t] = mon[k] < lvl;
        x_ratio = ratio(rated[k], mon[k]);
        l_ratio = ratio(rated[k], lvl);
      end
      else
      begin
        cond[t] = mon[k] > lvl;
        x_ratio = ratio(mon[k], rated[k]);
        l_ratio = ratio(lvl, rated[k]);
      end
      // the formula has no meaning at or below one per unit
      fixed[t] = (l_ratio <= `RATIO_ONE) || (x_ratio <= `RATIO_ONE);
      delay[t] = curve_ms(x_ratio, mult_eff[k], fixed[t]);
    end
  end

  // ----------------------------------------------------------------------------
  // timers and flags; no enable, the relays run from reset onward
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_st  = st;
    tick_hit = st.tick == 32'(TICK_CYCLES - 1);
    next_st.tick = tick_hit ? 32'h0 : st.tick + 32'h1;
    for (int t = 0; t < `NUM_TMR; t++)
    begin
      if (!cond[t])
        next_st.elapsed[t] = 32'h0;
      else if (tick_hit && st.elapsed[t] != `ELAPSED_MAX)
        next_st.elapsed[t] = st.elapsed[t] + 32'h1;
    end
    for (int f = 0; f < `NUM_FN; f++)
    begin
      // pre-alarm follows its condition; alarm sticks until reset
      next_st.pre[f] = cond[2*f] && (st.pre[f] || st.elapsed[2*f] >= delay[2*f]);
      if (cond[2*f+1] && st.elapsed[2*f+1] >= delay[2*f+1])
        next_st.alm[f] = 1'b1;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      st <= '0;
    else
      st <= next_st;
  end

  assign PRE_ALARM = st.pre;
  assign ALARM     = st.alm;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  sequence s_alm_rise;
    $rose(st.alm[`FN_OVC]) && $past(NRST);
  endsequence
  sequence s_held;
    cond[1] ##1 cond[1];
  endsequence

  a_ovc_largest_phase: assert property (mon[0] >= {2'h0, I_PHASE.a} &&
    mon[0] >= {2'h0, I_PHASE.b} && mon[0] >= {2'h0, I_PHASE.c})
    else $error("overcurrent input is not the largest phase");
  a_alarm_timed_out: assert property (s_alm_rise |->
    $past(cond[1]) && ($past(st.elapsed[1]) >= $past(delay[1])))
    else $error("alarm raised before its delay");
  a_alarm_stays_latched: assert property ($past(NRST) |->
    ((st.alm & $past(st.alm)) == $past(st.alm)))
    else $error("latched alarm cleared without reset");
  a_elapsed_restart: assert property (!cond[0] |=> st.elapsed[0] == 32'h0)
    else $error("elapsed time not restarted");
  a_pre_drops_out: assert property (!cond[0] |=> !st.pre[0])
    else $error("pre-alarm held without condition");
  a_elapsed_no_loss: assert property (s_held |-> st.elapsed[1] >= $past(st.elapsed[1]))
    else $error("elapsed time lost while condition held");
  a_vro_rated_volts: assert property ((vavg == {2'h0, RATED_V} && RATED_V != 16'h0) |->
    lvl_alm[1] == {2'h0, CFG[1].alm_level})
    else $error("restrained level changed at rated voltage");
  a_imb_rated_offset: assert property (lvl_pre[2] == {2'h0, CFG[2].pre_level} + rated[2])
    else $error("imbalance level missing rated offset");
  a_fixed_ten_sec: assert property ((fixed[1] && mult_eff[0] == `MULT_DEFAULT) |->
    delay[1] == 32'(`FIXED_B_MS))
    else $error("fixed delay is not ten seconds");
  a_mult_in_range: assert property (mult_eff[1] >= `MULT_MIN && mult_eff[1] <= `MULT_MAX)
    else $error("multiplier outside its range");

endmodule

// >>> hdl/relay_params.svh
// named constants for the inverse-time overcurrent relay block
// assumes a 10 MHz system clock and a measurement front end giving raw magnitudes
`ifndef RELAY_PARAMS_SVH
`define RELAY_PARAMS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS  100
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES    (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// curve constants, times in milliseconds
// ----------------------------------------------------------------------------
`define CURVE_A_MS     19610
`define CURVE_B_MS     491
`define CURVE_EXP      2
`define FIXED_A_MS     0
`define FIXED_B_MS     10000

// ----------------------------------------------------------------------------
// fixed point and multiplier limits (multiplier in hundredths)
// ----------------------------------------------------------------------------
`define RATIO_FRAC     8
`define RATIO_ONE      16'h0100
`define RATIO_MAX      16'h1000
`define POW_ONE        48'h0000_0001_0000
`define MULT_MIN       10'h001
`define MULT_MAX       10'h3E8
`define MULT_DEFAULT   10'h064
`define MULT_SCALE     48'h0000_0000_0064
`define ELAPSED_MAX    32'hFFFF_FFFF

// ----------------------------------------------------------------------------
// function slots
// ----------------------------------------------------------------------------
`define FN_OVC         0
`define FN_VRO         1
`define FN_IMB         2
`define NUM_FN         3
`define NUM_TMR        6

`endif

// >>> hdl/relay_pkg.sv
// types shared by the relay block and its bench
// assumes magnitudes are unsigned 16-bit values in the same units as their ratings
package relay_pkg;

  // ----------------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } phase_t;

  // levels in current units; multiplier in hundredths (0 selects 1.00)
  typedef struct packed {
    logic [15:0] pre_level;
    logic [15:0] alm_level;
    logic [9:0]  mult;
    logic        low_type;
  } relay_cfg_t;

  // ----------------------------------------------------------------------------
  // state: 1 ms prescaler, one elapsed counter per stage, flags per function
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      tick;
    logic [5:0][31:0] elapsed;
    logic [2:0]       pre;
    logic [2:0]       alm;
  } relay_state_t;

endpackage

// >>> tb/front_end_model.sv
// measurement front end model: holds phase current and voltage magnitudes
// assumes the bench calls apply between clock edges; values stay until replaced
module front_end_model
(
  input  wire logic            clk,
  output relay_pkg::phase_t    i_phase,
  output relay_pkg::phase_t    v_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  import relay_pkg::*;

  // ----------------------------------------------------------------------------
  // level outputs, changed only at the falling edge so the relay samples them clean
  // ----------------------------------------------------------------------------
  initial
  begin
    i_phase = '0;
    v_phase = '0;
  end

  task automatic apply(input phase_t i, input phase_t v);
    @(negedge clk);
    i_phase = i;
    v_phase = v;
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the inverse-time relay, prescaler cut to 10 clocks per ms
// assumes the relay's own assertions run inside it; delays checked with a 2 ms margin
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import relay_pkg::*;

  `define CHK(nm, e, g) check(nm, 16'(e), 16'(g))

  logic                clk = 1'b0;
  logic                nrst = 1'b0;
  logic [15:0]         rated_i = 16'h0064;
  logic [15:0]         rated_v = 16'h0064;
  relay_cfg_t [2:0]    cfg = '1;
  phase_t              i_phase;
  phase_t              v_phase;
  logic [2:0]          pre_alarm;
  logic [2:0]          alarm;
  int                  bad_count = 0;
  int                  tests_run = 0;

  // ----------------------------------------------------------------------------
  // clock, front end and relay
  // ----------------------------------------------------------------------------
  always #50 clk = ~clk;

  front_end_model fe (.clk(clk), .i_phase(i_phase), .v_phase(v_phase));

  inverse_time_relay #(.TICK_CYCLES(10)) dut (
    .CLK(clk), .NRST(nrst), .I_PHASE(i_phase), .V_PHASE(v_phase), .RATED_I(rated_i),
    .RATED_V(rated_v), .CFG(cfg), .PRE_ALARM(pre_alarm), .ALARM(alarm));

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // every slot parked high-type at full scale so no timer runs, then reset held for 4 clocks
  task automatic do_reset();
    @(negedge clk);
    for (int s = 0; s < 3; s++)
      set_cfg(s, 16'hFFFF, 16'hFFFF, 10'h000, 1'b0);
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
  endtask

  task automatic set_cfg(input int s, input logic [15:0] p, input logic [15:0] a,
                         input logic [9:0] m, input logic low);
    cfg[s] = '{pre_level: p, alm_level: a, mult: m, low_type: low};
  endtask

  // one ms is 10 clocks with the shortened prescaler
  task automatic wait_ms(input int n);
    repeat (n * 10) @(negedge clk);
  endtask

  // onset now; pre-alarm must be clear 2 ms before the delay and both flags set 2 ms after
  task automatic expect_trip(input int d, input logic [2:0] f);
    wait_ms(d - 2);
    `CHK("pre early", 3'h0, pre_alarm);
    wait_ms(4);
    `CHK("pre late", f, pre_alarm);
    `CHK("alarm late", f, alarm);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // watchdog: the tests need some 3900 clocks
  // ----------------------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    close_out();
  end

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial
  begin
    // largest phase 200 of rated 100 gives ratio 2, delay 70 ms at multiplier 0.01
    do_reset();
    set_cfg(0, 16'h0096, 16'h0096, 10'h001, 1'b0);
    set_cfg(1, 16'h00D2, 16'h00D2, 10'h001, 1'b0); // sum 220 exceeds 210, largest does not
    fe.apply('{16'h000A, 16'h00C8, 16'h000A}, '{16'h0064, 16'h0064, 16'h0064});
    wait_ms(30);
    fe.apply('{16'h000A, 16'h0064, 16'h000A}, '{16'h0064, 16'h0064, 16'h0064});
    fe.apply('{16'h000A, 16'h00C8, 16'h000A}, '{16'h0064, 16'h0064, 16'h0064});
    expect_trip(70, 3'h1);
    fe.apply('{16'h000A, 16'h000A, 16'h000A}, '{16'h0064, 16'h0064, 16'h0064});
    @(negedge clk);
    `CHK("pre drop", 3'h0, pre_alarm);
    wait_ms(5);
    `CHK("alarm held", 3'h1, alarm);
    // restraint: levels 400 at half voltage become 200; ratio 3 gives 29 ms
    // slot 0 trips on the same current but its own 1.00 multiplier keeps it near 2.9 s
    do_reset();
    set_cfg(0, 16'h00C8, 16'h00C8, 10'h000, 1'b0);
    set_cfg(1, 16'h0190, 16'h0190, 10'h001, 1'b0);
    fe.apply('{16'h012C, 16'h000A, 16'h000A}, '{16'h0032, 16'h0032, 16'h0032});
    expect_trip(29, 3'h2);
    // imbalance: widest gap 100 plus rated against 50 plus rated, ratio 2
    do_reset();
    set_cfg(2, 16'h0032, 16'h0032, 10'h001, 1'b0);
    fe.apply('{16'h0096, 16'h0032, 16'h0064}, '{16'h0064, 16'h0064, 16'h0064});
    expect_trip(70, 3'h4);
    // low type mirrors the ratio: rated 100 over 50 is 2, so 70 ms at 0.01
    do_reset();
    set_cfg(0, 16'h0050, 16'h0050, 10'h001, 1'b1);
    fe.apply('{16'h0032, 16'h0032, 16'h0032}, '{16'h0064, 16'h0064, 16'h0064});
    expect_trip(70, 3'h1);
    // high type with level below rated: fixed 10 s times 0.01 is 100 ms
    do_reset();
    set_cfg(0, 16'h0050, 16'h0050, 10'h001, 1'b0);
    fe.apply('{16'h0096, 16'h000A, 16'h000A}, '{16'h0064, 16'h0064, 16'h0064});
    expect_trip(100, 3'h1);
    do_reset();
    `CHK("alarm reset", 3'h0, alarm);
    close_out();
  end
endmodule
